// ### design/iodm_pkg.sv
// ==========================================================================
// Shared constants and carrier types for the I/O port drive-mode block.
package iodm_pkg;

   localparam int NPINS = 8;

   // Pins 6 and 7 are the USB-capable pair; pins 0 to 3 are special I/O pins.
   localparam logic [7:0] USB_PINS = 8'hC0;
   localparam logic [7:0] SPECIAL_PINS = 8'h0F;

   // Drive mode codes.
   localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
   localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
   localparam logic [2:0] DM_RES_UP = 3'h2;
   localparam logic [2:0] DM_RES_DOWN = 3'h3;
   localparam logic [2:0] DM_OD_LOW = 3'h4;
   localparam logic [2:0] DM_OD_HIGH = 3'h5;
   localparam logic [2:0] DM_STRONG = 3'h6;
   localparam logic [2:0] DM_RES_BOTH = 3'h7;

   // Register byte addresses.
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_PIN_STATE = 8'h04;
   localparam logic [7:0] OFS_DM0 = 8'h08;
   localparam logic [7:0] OFS_DM1 = 8'h0C;
   localparam logic [7:0] OFS_DM2 = 8'h10;
   localparam logic [7:0] OFS_OUT_SEL = 8'h14;
   localparam logic [7:0] OFS_BIDIR = 8'h18;
   localparam logic [7:0] OFS_SLEW = 8'h1C;
   localparam logic [7:0] OFS_IN_EN = 8'h20;
   localparam logic [7:0] OFS_REGULATED = 8'h24;
   localparam logic [7:0] OFS_USB_MODE = 8'h28;
   localparam logic [7:0] OFS_INT_TYPE = 8'h2C;
   localparam logic [7:0] OFS_INT_FLAGS = 8'h30;
   localparam logic [7:0] OFS_RST_CFG = 8'h34;
   localparam logic [7:0] OFS_CTRL = 8'h38;
   localparam logic [2:0] PIN_VIEW_BLOCK = 3'h2;

   // Pin-view word layout.
   localparam int PV_DATA = 0;
   localparam int PV_DM_LO = 1;
   localparam int PV_OUT_SEL = 4;
   localparam int PV_BIDIR = 5;
   localparam int PV_SLEW = 6;
   localparam int PV_IN_EN = 7;
   localparam int PV_STATE = 8;

   // Programmable reset-state word: drive mode in [2:0], data in [15:8].
   localparam logic [15:0] RST_CFG_RESET = 16'h0000;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [15:0] ZERO16 = 16'h0000;

   // Edge-type field, two bits per pin.
   localparam int IT_RISE = 0;
   localparam int IT_FALL = 1;

   typedef struct packed {
      logic drive_en;
      logic drive_val;
      logic pull_up;
      logic pull_down;
      logic ibuf_en;
      logic slew_slow;
   } iodm_pin_drv_t;

endpackage : iodm_pkg

// ### design/iodm_port.sv
// How it works
// - Each pin has its own three-bit drive mode, chosen independently.
// - Mode 0 turns off driver and input buffer; it is the reset default.
// - Mode 1 never drives and enables the input buffer.
// - Modes 2 and 3 mix resistive and strong drive by data value.
// - Modes 4 and 5 are open drain low and open drain high.
// - Mode 6 drives strong both ways; mode 7 resistive both ways.
// - Output value comes from fabric when selected, else from the data latch.
// - Pin input always feeds pin-state readback, and fabric when enabled.
// - Pin-state readback and output data latch are separate registers.
// - Special pins in regulated mode get no resistive drive.
// - USB-capable pin with drive enable set drives both levels strongly.
// - Drive enable clear: strong low, high-Z or resistive high by pull bit.
// - In USB mode the USB pins' drive and pull bits are ignored.
// - Port-wide mode writes never change the USB pins' mode bits.
// - Every pin can interrupt on rising, falling or both edges.
// - One combined interrupt request per port.
// - Data, drive mode, output select, bidir, slew and input enable bits are reachable by port view and by pin view.
// - The port's reset state is programmable by software.
// - Each pin has a fast or slow slew selection.
// - Bidirectional pins other than the USB pins go high-Z input while fabric output enable is low.
// - Each configured edge on a pin with its input buffer on sets its flag and raises the interrupt request.
`timescale 1ns/1ps
module iodm_port (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Digital fabric
   input wire logic [7:0] fab_out,
   input wire logic [7:0] fab_oe,
   output logic [7:0] fab_in,
   // Pins
   input wire logic [7:0] pin_in,
   output iodm_pkg::iodm_pin_drv_t [7:0] pin_drv,
   // Interrupt request
   output logic irq
);

   // ======================================================================
   // Reset release.
   logic rst_meta_ff;
   logic srst_n;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_ff <= 1'b0;
         srst_n <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         srst_n <= rst_meta_ff;
      end
   end

   // ======================================================================
   // Bus handshake: one wait cycle, then the access completes.
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic wr_go;
   logic pin_view;
   logic [2:0] pidx;

   assign wr_go = avs_write & ~wait_ff;
   assign pin_view = (avs_address[7:5] == iodm_pkg::PIN_VIEW_BLOCK);
   assign pidx = avs_address[4:2];
   assign avs_waitrequest = wait_ff;
   assign avs_readdata = rdata_ff;

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
         wait_ff <= 1'b1;
      else if ((avs_read | avs_write) & wait_ff)
         wait_ff <= 1'b0;
      else
         wait_ff <= 1'b1;
   end

   // ======================================================================
   // Configuration registers.
   logic [7:0] data_ff, dm0_ff, dm1_ff, dm2_ff, osel_ff, bidir_ff, slew_ff;
   logic [7:0] inen_ff, regul_ff, flags_ff, state_ff;
   logic usbmode_ff;
   logic [15:0] itype_ff, rstcfg_ff;
   logic [7:0] wd8;

   assign wd8 = avs_writedata[7:0];

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         data_ff <= iodm_pkg::ZERO8;
         dm0_ff <= iodm_pkg::ZERO8;
         dm1_ff <= iodm_pkg::ZERO8;
         dm2_ff <= iodm_pkg::ZERO8;
         osel_ff <= iodm_pkg::ZERO8;
         bidir_ff <= iodm_pkg::ZERO8;
         slew_ff <= iodm_pkg::ZERO8;
         inen_ff <= iodm_pkg::ZERO8;
         regul_ff <= iodm_pkg::ZERO8;
         usbmode_ff <= 1'b0;
         itype_ff <= iodm_pkg::ZERO16;
         rstcfg_ff <= iodm_pkg::RST_CFG_RESET;
      end
      else if (wr_go && pin_view)
      begin
         // Pin view reaches the same bits one pin at a time, USB pins included.
         data_ff[pidx] <= avs_writedata[iodm_pkg::PV_DATA];
         dm0_ff[pidx] <= avs_writedata[iodm_pkg::PV_DM_LO];
         dm1_ff[pidx] <= avs_writedata[iodm_pkg::PV_DM_LO + 1];
         dm2_ff[pidx] <= avs_writedata[iodm_pkg::PV_DM_LO + 2];
         osel_ff[pidx] <= avs_writedata[iodm_pkg::PV_OUT_SEL];
         bidir_ff[pidx] <= avs_writedata[iodm_pkg::PV_BIDIR];
         slew_ff[pidx] <= avs_writedata[iodm_pkg::PV_SLEW];
         inen_ff[pidx] <= avs_writedata[iodm_pkg::PV_IN_EN];
      end
      else if (wr_go)
      begin
         case (avs_address)
            iodm_pkg::OFS_DATA: data_ff <= wd8;
            iodm_pkg::OFS_DM0: dm0_ff <= (wd8 & ~iodm_pkg::USB_PINS) | (dm0_ff & iodm_pkg::USB_PINS);
            iodm_pkg::OFS_DM1: dm1_ff <= (wd8 & ~iodm_pkg::USB_PINS) | (dm1_ff & iodm_pkg::USB_PINS);
            iodm_pkg::OFS_DM2: dm2_ff <= (wd8 & ~iodm_pkg::USB_PINS) | (dm2_ff & iodm_pkg::USB_PINS);
            iodm_pkg::OFS_OUT_SEL: osel_ff <= wd8;
            iodm_pkg::OFS_BIDIR: bidir_ff <= wd8;
            iodm_pkg::OFS_SLEW: slew_ff <= wd8;
            iodm_pkg::OFS_IN_EN: inen_ff <= wd8;
            iodm_pkg::OFS_REGULATED: regul_ff <= wd8 & iodm_pkg::SPECIAL_PINS;
            iodm_pkg::OFS_USB_MODE: usbmode_ff <= avs_writedata[0];
            iodm_pkg::OFS_INT_TYPE: itype_ff <= avs_writedata[15:0];
            iodm_pkg::OFS_RST_CFG: rstcfg_ff <= avs_writedata[15:0];
            iodm_pkg::OFS_CTRL:
            begin
               // Applying the programmed reset state is port-wide, so it spares
               // the USB pins' mode bits just like a port-view mode write.
               if (avs_writedata[0])
               begin
                  data_ff <= rstcfg_ff[15:8];
                  dm0_ff <= ({8{rstcfg_ff[0]}} & ~iodm_pkg::USB_PINS) | (dm0_ff & iodm_pkg::USB_PINS);
                  dm1_ff <= ({8{rstcfg_ff[1]}} & ~iodm_pkg::USB_PINS) | (dm1_ff & iodm_pkg::USB_PINS);
                  dm2_ff <= ({8{rstcfg_ff[2]}} & ~iodm_pkg::USB_PINS) | (dm2_ff & iodm_pkg::USB_PINS);
               end
            end
            default: data_ff <= data_ff;
         endcase
      end
   end

   // ======================================================================
   // Read data, captured in the wait cycle so it stands at the completing edge.
   always_comb
   begin
      nxt_rdata = 32'h00000000;
      if (pin_view)
      begin
         nxt_rdata[iodm_pkg::PV_DATA] = data_ff[pidx];
         nxt_rdata[iodm_pkg::PV_DM_LO + 2 -: 3] = {dm2_ff[pidx], dm1_ff[pidx], dm0_ff[pidx]};
         nxt_rdata[iodm_pkg::PV_OUT_SEL] = osel_ff[pidx];
         nxt_rdata[iodm_pkg::PV_BIDIR] = bidir_ff[pidx];
         nxt_rdata[iodm_pkg::PV_SLEW] = slew_ff[pidx];
         nxt_rdata[iodm_pkg::PV_IN_EN] = inen_ff[pidx];
         nxt_rdata[iodm_pkg::PV_STATE] = state_ff[pidx];
      end
      else
      begin
         case (avs_address)
            iodm_pkg::OFS_DATA: nxt_rdata[7:0] = data_ff;
            iodm_pkg::OFS_PIN_STATE: nxt_rdata[7:0] = state_ff;
            iodm_pkg::OFS_DM0: nxt_rdata[7:0] = dm0_ff;
            iodm_pkg::OFS_DM1: nxt_rdata[7:0] = dm1_ff;
            iodm_pkg::OFS_DM2: nxt_rdata[7:0] = dm2_ff;
            iodm_pkg::OFS_OUT_SEL: nxt_rdata[7:0] = osel_ff;
            iodm_pkg::OFS_BIDIR: nxt_rdata[7:0] = bidir_ff;
            iodm_pkg::OFS_SLEW: nxt_rdata[7:0] = slew_ff;
            iodm_pkg::OFS_IN_EN: nxt_rdata[7:0] = inen_ff;
            iodm_pkg::OFS_REGULATED: nxt_rdata[7:0] = regul_ff;
            iodm_pkg::OFS_USB_MODE: nxt_rdata[0] = usbmode_ff;
            iodm_pkg::OFS_INT_TYPE: nxt_rdata[15:0] = itype_ff;
            iodm_pkg::OFS_INT_FLAGS: nxt_rdata[7:0] = flags_ff;
            iodm_pkg::OFS_RST_CFG: nxt_rdata[15:0] = rstcfg_ff;
            default: nxt_rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
         rdata_ff <= 32'h00000000;
      else if (avs_read & wait_ff)
         rdata_ff <= nxt_rdata;
   end

   // ======================================================================
   // Input synchroniser; the first stage feeds only the second.
   logic [7:0] sync1_ff, prev_ff;

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         sync1_ff <= iodm_pkg::ZERO8;
         state_ff <= iodm_pkg::ZERO8;
         prev_ff <= iodm_pkg::ZERO8;
      end
      else
      begin
         sync1_ff <= pin_in;
         state_ff <= sync1_ff;
         prev_ff <= state_ff;
      end
   end

   // ======================================================================
   // Per-pin drive decode and edge detection.
   iodm_pkg::iodm_pin_drv_t [7:0] nxt_drv;
   iodm_pkg::iodm_pin_drv_t [7:0] drv_ff;
   logic [7:0] dval, edge_ev, nxt_fab_in, fab_in_ff;

   assign pin_drv = drv_ff;
   assign fab_in = fab_in_ff;

   for (genvar i = 0; i < iodm_pkg::NPINS; i++)
   begin : g_pin
      logic [2:0] mode;
      logic sh, sl, rh, rl;

      assign dval[i] = osel_ff[i] ? fab_out[i] : data_ff[i];
      // A bidirectional pin other than a USB pin falls back to digital input while fabric disables it.
      assign mode = (bidir_ff[i] & ~fab_oe[i]) ? iodm_pkg::DM_HIZ_DIGITAL
                                               : {dm2_ff[i], dm1_ff[i], dm0_ff[i]};

      always_comb
      begin
         sh = 1'b0;
         sl = 1'b0;
         rh = 1'b0;
         rl = 1'b0;
         case (mode)
            iodm_pkg::DM_HIZ_ANALOG: sh = 1'b0;
            iodm_pkg::DM_HIZ_DIGITAL: sh = 1'b0;
            iodm_pkg::DM_RES_UP:
            begin
               rh = 1'b1;
               sl = 1'b1;
            end
            iodm_pkg::DM_RES_DOWN:
            begin
               sh = 1'b1;
               rl = 1'b1;
            end
            iodm_pkg::DM_OD_LOW: sl = 1'b1;
            iodm_pkg::DM_OD_HIGH: sh = 1'b1;
            iodm_pkg::DM_STRONG:
            begin
               sh = 1'b1;
               sl = 1'b1;
            end
            iodm_pkg::DM_RES_BOTH:
            begin
               rh = 1'b1;
               rl = 1'b1;
            end
            default: sh = 1'b0;
         endcase
         // The regulated output stage has no resistor path, so it floats instead.
         if (iodm_pkg::SPECIAL_PINS[i] && regul_ff[i])
         begin
            rh = 1'b0;
            rl = 1'b0;
         end
         nxt_drv[i].drive_val = dval[i];
         nxt_drv[i].slew_slow = slew_ff[i];
         if (iodm_pkg::USB_PINS[i] && usbmode_ff)
         begin
            // The USB transceiver owns the pin; this port stays out of the way.
            nxt_drv[i].drive_en = 1'b0;
            nxt_drv[i].pull_up = 1'b0;
            nxt_drv[i].pull_down = 1'b0;
            nxt_drv[i].ibuf_en = 1'b0;
         end
         else if (iodm_pkg::USB_PINS[i])
         begin
            nxt_drv[i].drive_en = dm0_ff[i] | ~dval[i];
            nxt_drv[i].pull_up = dval[i] & ~dm0_ff[i] & dm1_ff[i];
            nxt_drv[i].pull_down = 1'b0;
            nxt_drv[i].ibuf_en = 1'b1;
         end
         else
         begin
            nxt_drv[i].drive_en = dval[i] ? sh : sl;
            nxt_drv[i].pull_up = dval[i] & rh;
            nxt_drv[i].pull_down = ~dval[i] & rl;
            nxt_drv[i].ibuf_en = (mode != iodm_pkg::DM_HIZ_ANALOG);
         end
      end

      assign nxt_fab_in[i] = inen_ff[i] & nxt_drv[i].ibuf_en & state_ff[i];
      assign edge_ev[i] = nxt_drv[i].ibuf_en &
                          ((itype_ff[2 * i + iodm_pkg::IT_RISE] & state_ff[i] & ~prev_ff[i]) |
                           (itype_ff[2 * i + iodm_pkg::IT_FALL] & ~state_ff[i] & prev_ff[i]));
   end

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         drv_ff <= '0;
         fab_in_ff <= iodm_pkg::ZERO8;
      end
      else
      begin
         drv_ff <= nxt_drv;
         fab_in_ff <= nxt_fab_in;
      end
   end

   // ======================================================================
   // Interrupt flags: write one to clear, a new edge wins over the clear.
   logic irq_ff;
   logic [7:0] flag_clr;

   assign flag_clr = (wr_go && !pin_view && avs_address == iodm_pkg::OFS_INT_FLAGS) ? wd8
                                                                                    : iodm_pkg::ZERO8;
   assign irq = irq_ff;

   always_ff @(posedge clk or negedge srst_n)
   begin
      if (!srst_n)
      begin
         flags_ff <= iodm_pkg::ZERO8;
         irq_ff <= 1'b0;
      end
      else
      begin
         flags_ff <= (flags_ff & ~flag_clr) | edge_ev;
         irq_ff <= |flags_ff;
      end
   end

   // ======================================================================
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!srst_n);

   property p_mode0_off;
      (g_pin[4].mode == iodm_pkg::DM_HIZ_ANALOG) |=> (!pin_drv[4].drive_en && !pin_drv[4].ibuf_en
                                                   && !pin_drv[4].pull_up);
   endproperty
   a_mode0_off: assert property (p_mode0_off) else $error("mode 0 pin not fully off");

   property p_mode1_input;
      (g_pin[4].mode == iodm_pkg::DM_HIZ_DIGITAL) |=> (!pin_drv[4].drive_en && pin_drv[4].ibuf_en);
   endproperty
   a_mode1_input: assert property (p_mode1_input) else $error("mode 1 pin not an input");

   property p_strong_data;
      (g_pin[4].mode == iodm_pkg::DM_STRONG && !osel_ff[4]) |=>
         (pin_drv[4].drive_en && pin_drv[4].drive_val == $past(data_ff[4]));
   endproperty
   a_strong_data: assert property (p_strong_data) else $error("strong mode not driving latch");

   property p_fabric_out;
      (g_pin[4].mode == iodm_pkg::DM_STRONG && osel_ff[4]) |=>
         (pin_drv[4].drive_val == $past(fab_out[4]));
   endproperty
   a_fabric_out: assert property (p_fabric_out) else $error("fabric output not selected");

   property p_bidir_release;
      (bidir_ff[4] && !fab_oe[4]) |=> (!pin_drv[4].drive_en && !pin_drv[4].pull_up);
   endproperty
   a_bidir_release: assert property (p_bidir_release) else $error("bidir pin still driven");

   property p_usb_open;
      (!usbmode_ff && !dm0_ff[7] && !dm1_ff[7] && !osel_ff[7] && data_ff[7]) |=>
         (!pin_drv[7].drive_en && !pin_drv[7].pull_up);
   endproperty
   a_usb_open: assert property (p_usb_open) else $error("usb pin high not released");

   property p_usb_mode;
      usbmode_ff |=> (!pin_drv[7].drive_en && !pin_drv[6].drive_en && !pin_drv[7].pull_up);
   endproperty
   a_usb_mode: assert property (p_usb_mode) else $error("usb mode pin driven by port");

   property p_usb_dm_kept;
      (wr_go && avs_address == iodm_pkg::OFS_DM0) |=> (dm0_ff[7:6] == $past(dm0_ff[7:6]));
   endproperty
   a_usb_dm_kept: assert property (p_usb_dm_kept) else $error("port write changed usb mode");

   property p_edge_irq;
      (itype_ff[9:8] == 2'h1 && g_pin[4].mode == iodm_pkg::DM_HIZ_DIGITAL && state_ff[4] && !prev_ff[4])
         |=> flags_ff[4] ##1 irq;
   endproperty
   a_edge_irq: assert property (p_edge_irq) else $error("rising edge lost");

   property p_sync_delay;
      1'b1 |-> ##2 (state_ff == $past(pin_in, 2));
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("pin state not two stages late");

   c_write: cover property (wr_go ##1 avs_waitrequest);
   c_irq: cover property ($rose(irq));
   c_bidir: cover property (bidir_ff[4] && $fell(fab_oe[4]));

endmodule : iodm_port

// ### bench/iodm_board.sv
`timescale 1ns/1ps
// ==========================================================================
// Board model
// A board source may drive any pin and wins over the device. A pin that
// nobody drives settles through a weak board pull-down unless the device
// pulls it up.
module iodm_board (
   // Device side
   input wire iodm_pkg::iodm_pin_drv_t [7:0] pin_drv,
   // Board sources
   input wire logic [7:0] ext_en,
   input wire logic [7:0] ext_val,
   // Levels seen by the device
   output logic [7:0] pin_in
);
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (pin_drv[i].drive_en)
            pin_in[i] = pin_drv[i].drive_val;
         else
            pin_in[i] = pin_drv[i].pull_up;
      end
   end
endmodule : iodm_board

// ### bench/test_io_port_drive_mode_control.sv
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench
module test_io_port_drive_mode_control;
   logic clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
   logic [7:0] avs_address, fab_out, fab_oe, fab_in, pin_in, ext_en, ext_val, dat;
   logic [31:0] avs_writedata, avs_readdata, q;
   iodm_pkg::iodm_pin_drv_t [7:0] pin_drv;
   logic [2:0] md [8];
   logic usb_mode;
   int err_count, cmp_count, seed, p, n;

   iodm_port uut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .fab_out(fab_out), .fab_oe(fab_oe), .fab_in(fab_in), .pin_in(pin_in),
      .pin_drv(pin_drv), .irq(irq));
   iodm_board board (.pin_drv(pin_drv), .ext_en(ext_en), .ext_val(ext_val),
      .pin_in(pin_in));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ==========================================================================
   // Checking and closing
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Entered just after a rising edge; holds the request until waitrequest
   // is seen low, then releases and lets one edge pass.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (avs_waitrequest !== 1'b0 && k < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 50)
      begin
         err_count++;
         give_verdict();
      end
      @(posedge clk);
   endtask : bus

   // ==========================================================================
   // Expected pin drive as {strong on, strong high, pull up, pull down, buffer}
   function automatic logic [4:0] exp_drv(input int i);
      logic d;
      logic [2:0] m;
      d = dat[i];
      m = md[i];
      if (i >= 6)
         return usb_mode ? 5'h00 : {m[0] | ~d, d & m[0], d & ~m[0] & m[1], 2'b01};
      case (m)
         3'h0: return 5'h00;
         3'h1: return 5'h01;
         3'h2: return d ? 5'h05 : 5'h11;
         3'h3: return d ? 5'h19 : 5'h03;
         3'h4: return d ? 5'h01 : 5'h11;
         3'h5: return d ? 5'h19 : 5'h01;
         3'h6: return {1'b1, d, 3'b001};
         default: return d ? 5'h05 : 5'h03;
      endcase
   endfunction : exp_drv

   task automatic chk_pins();
      repeat (2) @(posedge clk);
      for (int i = 0; i < 8; i++)
         chk({pin_drv[i].drive_en, pin_drv[i].drive_en & pin_drv[i].drive_val,
            pin_drv[i].pull_up, pin_drv[i].pull_down, pin_drv[i].ibuf_en},
            exp_drv(i));
   endtask : chk_pins

   initial
   begin
      err_count = 0;
      cmp_count = 0;
      seed = 98;
      rst_n = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {fab_out, fab_oe, ext_en, ext_val, dat} = '0;
      usb_mode = 1'b0;
      for (int i = 0; i < 8; i++)
         md[i] = 3'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk_pins();
      bus(1'b0, 8'h3C, 32'h0);
      chk(q, 32'h0);
      // Random modes and data through the per-pin view, checked on all pins.
      for (int t = 0; t < 32; t++)
      begin
         p = $random(seed) & 7;
         md[p] = $random(seed);
         dat[p] = $random(seed);
         bus(1'b1, 8'h40 + 8'(4 * p), {28'h0, md[p], dat[p]});
         chk_pins();
         bus(1'b0, iodm_pkg::OFS_DM1, 32'h0);
         for (int i = 0; i < 8; i++)
            chk(q[i], md[i][1]);
      end
      // A port-wide write must leave the USB pins' mode bits alone.
      bus(1'b1, iodm_pkg::OFS_DM0, 32'hFF);
      for (int i = 0; i < 6; i++)
         md[i][0] = 1'b1;
      bus(1'b0, iodm_pkg::OFS_DM0, 32'h0);
      chk(q[5:0], 6'h3F);
      chk(q[7:6], {md[7][0], md[6][0]});
      chk_pins();
      bus(1'b1, iodm_pkg::OFS_USB_MODE, 32'h1);
      usb_mode = 1'b1;
      chk_pins();
      bus(1'b1, iodm_pkg::OFS_USB_MODE, 32'h0);
      usb_mode = 1'b0;
      // Regulated special pin in resistive mode loses both resistive legs.
      bus(1'b1, 8'h40, 32'h0F);
      bus(1'b1, iodm_pkg::OFS_REGULATED, 32'h1);
      repeat (2) @(posedge clk);
      chk({pin_drv[0].pull_up, pin_drv[0].pull_down}, 2'b00);
      // Pin 5: strong mode, fabric output, bidirectional, slow slew.
      fab_out <= 8'h20;
      fab_oe <= 8'h20;
      bus(1'b1, 8'h54, 32'h7C);
      repeat (2) @(posedge clk);
      chk({pin_drv[5].drive_en, pin_drv[5].drive_val, pin_drv[5].slew_slow}, 3'h7);
      fab_out <= 8'h00;
      repeat (3) @(posedge clk);
      chk({pin_drv[5].drive_en, pin_drv[5].drive_val}, 2'b10);
      fab_oe <= 8'h00;
      repeat (3) @(posedge clk);
      chk({pin_drv[5].drive_en, pin_drv[5].ibuf_en}, 2'b01);
      // Pin 3: digital input, rising-edge interrupt, latch holds 0.
      ext_en <= 8'h08;
      bus(1'b1, 8'h4C, 32'h82);
      bus(1'b1, iodm_pkg::OFS_INT_TYPE, 32'h40);
      bus(1'b1, iodm_pkg::OFS_INT_FLAGS, 32'hFF);
      repeat (4) @(posedge clk);
      chk(irq, 1'b0);
      ext_val <= 8'h08;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (irq !== 1'b1 && n < 10);
      chk(irq, 1'b1);
      if (n >= 10)
         give_verdict();
      bus(1'b0, iodm_pkg::OFS_INT_FLAGS, 32'h0);
      chk(q, 32'h08);
      bus(1'b0, iodm_pkg::OFS_PIN_STATE, 32'h0);
      chk(q[3], 1'b1);
      bus(1'b0, iodm_pkg::OFS_DATA, 32'h0);
      chk(q[3], 1'b0);
      chk(fab_in[3], 1'b1);
      bus(1'b1, iodm_pkg::OFS_INT_FLAGS, 32'h08);
      ext_val <= 8'h00;
      repeat (6) @(posedge clk);
      chk(irq, 1'b0);
      // Programmed reset state applied to the port; data checked on all pins, only the OFS_DM2 mode bit on pins 0 to 5.
      bus(1'b1, iodm_pkg::OFS_RST_CFG, 32'hA506);
      bus(1'b1, iodm_pkg::OFS_CTRL, 32'h1);
      bus(1'b0, iodm_pkg::OFS_DATA, 32'h0);
      chk(q, 32'hA5);
      bus(1'b0, iodm_pkg::OFS_DM2, 32'h0);
      chk(q[5:0], 6'h3F);
      give_verdict();
   end
endmodule : test_io_port_drive_mode_control
